// ===== rtl/hpi_device.sv
// Device end of the host register port: clear, mask and identity registers,
// interrupt status and pin, ack/ready handshake, port A peripheral routing.
// Assumes status events arrive as one-cycle pulses from the datapaths.
//
// Notes on behaviour
// - Bits 7 and 6 of status and mask read as zero
// - Address 0x19 writes clear, reads status
// - Writing one gives one clear pulse
// - Writing zero leaves status bit unchanged
// - Mask at 0x1A gates status onto pin
// - Mask one blocks pin; status still sets
// - Reset sets all six mask bits
// - Host may poll with everything masked
// - Address 0x1F returns fixed identity code
// - Style pin selects strobe scheme and polarities
// - Host presents five-bit register address
// - Read/write high reads, low writes
// - Write strobe low writes, rise ends
// - Read strobe low reads, rise ends
// - Select plus data strobe low starts access
// - Select plus either strobe starts access
// - Peripheral select routes cycle to port A
// - Data strobe rise ends the access
// - Ack pulled low when data latched/valid
// - Ready low at start, high when done
// - Interrupt pin polarity and reset state
// - Status bits clear on hard reset
module hpi_device (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  hpi_bus_if.device bus,
  input wire logic [5:0] irq_event_in,
  input wire logic [7:0] periph_rdata_in,
  output logic periph_cycle_out,
  output logic periph_write_out,
  output logic [7:0] periph_wdata_out,
  output logic [5:0] status_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} hpi_dstate_e;

  logic [4:0] sync_r;
  logic reg_sel_n_s, pa_sel_n_s, ds_n_s, rw_n_s, iow_s;
  logic active_s, is_write_s;
  hpi_dstate_e state_r;
  logic [1:0] cnt_r;
  logic [5:0] status_r;
  logic [5:0] mask_r;
  logic [5:0] clear_pulse_r;
  logic [7:0] rdata_r;
  logic to_periph_r;
  logic write_r;
  logic ack_val_r, ack_oe_r, irq_val_r, irq_oe_r, dev_oe_r;
  logic periph_cycle_r;
  logic irq_any;
  logic latch_now;

  hpi_sync2 #(.W(5), .INIT(5'h1F)) hpi_sync2_inst (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .async_in({bus.reg_select_n, bus.periph_a_select_n, bus.data_strobe_n, bus.read_write_n,
      bus.io_write_strobe_n}),
    .sync_out(sync_r)
  );
  assign {reg_sel_n_s, pa_sel_n_s, ds_n_s, rw_n_s, iow_s} = sync_r;

  // In separate style the data strobe pin carries the read strobe
  always_comb begin
    if (bus.bus_style_select) begin
      active_s = !ds_n_s && (!reg_sel_n_s || !pa_sel_n_s);
      is_write_s = !rw_n_s;
    end else begin
      active_s = (!ds_n_s || !iow_s) && (!reg_sel_n_s || !pa_sel_n_s);
      is_write_s = !iow_s;
    end
  end

  function automatic logic [7:0] read_mux(input logic [4:0] a, input logic [5:0] st, input logic [5:0] mk);
    case (a)
      hpi_pkg::ADDR_IRQ_CLEAR: read_mux = {2'h0, st};
      hpi_pkg::ADDR_IRQ_MASK: read_mux = {2'h0, mk};
      hpi_pkg::ADDR_CHIP_ID: read_mux = hpi_pkg::CHIP_ID_VALUE;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // Cycle sequencer; wait state gives data time to settle before ack
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 2'h0;
      to_periph_r <= 1'b0;
      write_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (active_s) begin
            state_r <= ST_WAIT;
            cnt_r <= hpi_pkg::ACK_CNT_INIT;
            to_periph_r <= reg_sel_n_s;
            write_r <= is_write_s;
          end
        end
        ST_WAIT: begin
          // Strobe dropped before the ack: abandon the access
          if (!active_s) begin
            state_r <= ST_IDLE;
          end else if (cnt_r == 2'h1) begin
            state_r <= ST_DONE;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        ST_DONE: begin
          if (!active_s) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Data is taken on the last wait clock, one clock before ack or ready
  assign latch_now = (state_r == ST_WAIT) && active_s && (cnt_r == 2'h1);

  // Register writes and read capture at the end of the wait state
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mask_r <= hpi_pkg::MASK_RESET;
      clear_pulse_r <= 6'h00;
      rdata_r <= 8'h00;
      periph_wdata_out <= 8'h00;
    end else begin
      clear_pulse_r <= 6'h00;
      if (latch_now) begin
        if (to_periph_r) begin
          periph_wdata_out <= bus.data_host;
          rdata_r <= periph_rdata_in;
        end else if (write_r) begin
          if (bus.addr == hpi_pkg::ADDR_IRQ_CLEAR) begin
            clear_pulse_r <= bus.data_host[5:0];
          end
          if (bus.addr == hpi_pkg::ADDR_IRQ_MASK) begin
            mask_r <= bus.data_host[5:0];
          end
        end else begin
          rdata_r <= read_mux(bus.addr, status_r, mask_r);
        end
      end
    end
  end

  // Event set wins over a same-cycle clear
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_r <= hpi_pkg::STATUS_RESET;
    end else begin
      status_r <= (status_r & ~clear_pulse_r) | irq_event_in;
    end
  end

  assign irq_any = |(status_r & ~mask_r);

  // Pin drivers
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_val_r <= 1'b0;
      ack_oe_r <= 1'b0;
      irq_val_r <= 1'b0;
      irq_oe_r <= 1'b0;
      dev_oe_r <= 1'b0;
      periph_cycle_r <= 1'b0;
    end else begin
      if (bus.bus_style_select) begin
        irq_val_r <= 1'b0;
        irq_oe_r <= irq_any;
        ack_val_r <= 1'b0;
        ack_oe_r <= (state_r == ST_DONE) && active_s;
      end else begin
        irq_val_r <= irq_any;
        irq_oe_r <= 1'b1;
        ack_val_r <= (state_r == ST_DONE);
        ack_oe_r <= active_s;
      end
      dev_oe_r <= (state_r == ST_DONE) && active_s && !write_r;
      periph_cycle_r <= (state_r != ST_IDLE) && active_s && to_periph_r;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      periph_write_out <= 1'b0;
    end else if (state_r == ST_IDLE && active_s) begin
      periph_write_out <= is_write_s;
    end
  end

  assign bus.ack_val = ack_val_r;
  assign bus.ack_oe = ack_oe_r;
  assign bus.irq_val = irq_val_r;
  // Driven output in separate style is never floated, reset included
  assign bus.irq_oe = bus.bus_style_select ? irq_oe_r : 1'b1;
  assign bus.data_dev = rdata_r;
  assign bus.data_dev_oe = dev_oe_r;
  assign periph_cycle_out = periph_cycle_r;
  assign status_out = status_r;
endmodule : hpi_device

// ===== rtl/hpi_pkg.sv
// Shared constants for the host port and its interrupt service registers.
// Assumes one 25 MHz clock shared by both ends of the port.
package hpi_pkg;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h19;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h1A;
  localparam logic [4:0] ADDR_CHIP_ID = 5'h1F;
  localparam int IRQ_BITS = 6;
  localparam logic [5:0] MASK_RESET = 6'h3F;
  localparam logic [5:0] STATUS_RESET = 6'h00;
  localparam logic [7:0] CHIP_ID_VALUE = 8'h5A; // Arbitrary identity value
  localparam int BIT_DONE_A = 0;
  localparam int BIT_DONE_B = 1;
  localparam int BIT_PARITY_A = 2;
  localparam int BIT_PARITY_B = 3;
  localparam int BIT_DECODE_ERR = 4;
  localparam int BIT_COMPARE = 5;
  localparam int ACK_DELAY = 2;
  localparam int HOLD_CYCLES = 3;
  localparam logic [1:0] ACK_CNT_INIT = 2'h2;
  localparam logic [1:0] HOLD_CNT_INIT = 2'h3;
endpackage : hpi_pkg

// ===== rtl/hpi_bus_if.sv
// Pin bundle between host processor and the device register port.
// Assumes the bench resolves two-way and open-drain pins from the enables.
interface hpi_bus_if;
  logic bus_style_select;
  logic [4:0] addr;
  logic reg_select_n;
  logic periph_a_select_n;
  logic data_strobe_n;
  logic read_write_n;
  logic io_write_strobe_n;
  logic io_read_strobe_n;
  logic [7:0] data_host;
  logic data_host_oe;
  logic [7:0] data_dev;
  logic data_dev_oe;
  logic ack_val;
  logic ack_oe;
  logic irq_val;
  logic irq_oe;
  modport device (input bus_style_select, addr, reg_select_n, periph_a_select_n, data_strobe_n, read_write_n,
    io_write_strobe_n, io_read_strobe_n, data_host, data_host_oe,
    output data_dev, data_dev_oe, ack_val, ack_oe, irq_val, irq_oe);
  modport host (output bus_style_select, addr, reg_select_n, periph_a_select_n, data_strobe_n, read_write_n,
    io_write_strobe_n, io_read_strobe_n, data_host, data_host_oe,
    input data_dev, data_dev_oe, ack_val, ack_oe, irq_val, irq_oe);
endinterface : hpi_bus_if

// ===== rtl/hpi_sync2.sv
// Two-stage synchroniser for a bundle of host strobes.
// Assumes inputs may change at any time relative to clock_in.
module hpi_sync2 #(
  parameter int W = 5,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= INIT;
      sync_out <= INIT;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : hpi_sync2

// ===== rtl/hpi_host.sv
// Host end of the register port: runs one read or write per request.
// Assumes style pin is static and the bench resolves ack/ready levels.
module hpi_host (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  hpi_bus_if.host bus,
  input wire logic style_in,
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic req_periph_in,
  input wire logic [4:0] req_addr_in,
  input wire logic [7:0] req_wdata_in,
  input wire logic ack_level_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] rdata_out
);
  typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_STROBE, HS_HOLD} hpi_hstate_e;

  hpi_hstate_e state_r;
  logic [1:0] hold_r;
  logic wr_r, per_r, sel_r, strb_r;
  logic [4:0] addr_r;
  logic [7:0] wdata_r;
  logic ack_seen;
  logic rdy_low_r;

  // Ready style: high when done; strobe style: ack pulled low
  assign ack_seen = style_in ? (!ack_level_in) : (ack_level_in && rdy_low_r);

  // Ready floats high on the pull-up, so a high only counts after the low that opens the cycle
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdy_low_r <= 1'b0;
    end else if (state_r != HS_STROBE) begin
      rdy_low_r <= 1'b0;
    end else if (!ack_level_in) begin
      rdy_low_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= HS_IDLE;
      hold_r <= 2'h0;
      wr_r <= 1'b0;
      per_r <= 1'b0;
      sel_r <= 1'b0;
      strb_r <= 1'b0;
      addr_r <= 5'h00;
      wdata_r <= 8'h00;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      done_out <= 1'b0;
      case (state_r)
        HS_IDLE: begin
          if (req_in) begin
            state_r <= HS_SETUP;
            wr_r <= req_write_in;
            per_r <= req_periph_in;
            addr_r <= req_addr_in;
            wdata_r <= req_wdata_in;
            sel_r <= 1'b1;
            busy_out <= 1'b1;
          end
        end
        HS_SETUP: begin
          strb_r <= 1'b1; // Select settles before the strobe falls
          state_r <= HS_STROBE;
        end
        HS_STROBE: begin
          if (ack_seen) begin
            if (!wr_r) begin
              rdata_out <= bus.data_dev;
            end
            strb_r <= 1'b0;
            hold_r <= hpi_pkg::HOLD_CNT_INIT;
            state_r <= HS_HOLD;
          end
        end
        HS_HOLD: begin
          if (hold_r == 2'h1) begin
            sel_r <= 1'b0;
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state_r <= HS_IDLE;
          end else begin
            hold_r <= hold_r - 2'h1;
          end
        end
        default: state_r <= HS_IDLE;
      endcase
    end
  end

  assign bus.bus_style_select = style_in;
  assign bus.addr = addr_r;
  assign bus.reg_select_n = !(sel_r && !per_r);
  assign bus.periph_a_select_n = !(sel_r && per_r);
  assign bus.data_strobe_n = style_in ? !strb_r : !(strb_r && !wr_r);
  assign bus.read_write_n = style_in ? !wr_r : !(strb_r && wr_r);
  assign bus.io_write_strobe_n = !(strb_r && wr_r);
  assign bus.io_read_strobe_n = !(strb_r && !wr_r);
  assign bus.data_host = wdata_r;
  assign bus.data_host_oe = sel_r && wr_r;
endmodule : hpi_host

// ===== testbench/hpi_properties.sv
// Pin-level checks on the host port bundle.
// Assumes the style pin only changes while reset is held.
module hpi_properties (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic bus_style_select,
  input wire logic reg_select_n,
  input wire logic periph_a_select_n,
  input wire logic data_strobe_n,
  input wire logic read_write_n,
  input wire logic io_write_strobe_n,
  input wire logic io_read_strobe_n,
  input wire logic data_host_oe,
  input wire logic data_dev_oe,
  input wire logic ack_val,
  input wire logic ack_oe,
  input wire logic irq_val,
  input wire logic irq_oe
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic stb_lo;
  logic sel_lo;
  logic [3:0] idle_r;
  assign stb_lo = !data_strobe_n || (!bus_style_select && !io_write_strobe_n);
  assign sel_lo = !reg_select_n || !periph_a_select_n;
  // Strobe rise is seen late through the synchroniser, so allow a margin
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      idle_r <= 4'h0;
    else if (stb_lo)
      idle_r <= 4'h0;
    else if (idle_r != 4'hF)
      idle_r <= idle_r + 4'h1;
  end
  a_idle_pins_off: assert property (idle_r >= 4'h6 |-> !ack_oe && !data_dev_oe)
    else $error("driven while idle");
  a_od_ack_low: assert property (bus_style_select && ack_oe |-> !ack_val)
    else $error("ack driven high");
  a_ack_in_cycle: assert property ($rose(ack_oe) |-> stb_lo && sel_lo)
    else $error("ack outside cycle");
  a_ack_bounded: assert property (bus_style_select && $fell(data_strobe_n) && sel_lo |-> ##[2:12] ack_oe)
    else $error("ack late");
  a_ready_low_first: assert property (!bus_style_select && $rose(ack_oe) |-> !ack_val)
    else $error("ready not low");
  a_ready_rises: assert property (!bus_style_select && $rose(ack_oe) |-> ##[1:8] (ack_oe && ack_val))
    else $error("ready late");
  a_irq_od_low: assert property (bus_style_select && irq_oe |-> !irq_val)
    else $error("irq driven high");
  a_irq_driven: assert property (!bus_style_select && !$past(sys_rst_in) |-> irq_oe)
    else $error("irq undriven");
  a_dev_data_read: assert property (data_dev_oe && stb_lo |-> (bus_style_select ? read_write_n : io_write_strobe_n))
    else $error("data driven in write");
  a_irq_reset_off: assert property ($past(sys_rst_in) |-> (bus_style_select ? !irq_oe : !irq_val))
    else $error("irq after reset");
  a_read_strobe_twin: assert property (!bus_style_select |-> io_read_strobe_n == data_strobe_n)
    else $error("read strobe pins differ");
  a_data_no_clash: assert property (!(data_host_oe && data_dev_oe))
    else $error("both ends drive data");
  c_ds_ack: cover property (bus_style_select && $rose(ack_oe));
  c_ready: cover property (!bus_style_select && ack_oe && ack_val);
  c_irq: cover property (irq_oe && (bus_style_select ? !irq_val : irq_val));
endmodule : hpi_properties

// ===== testbench/host_port_irq_gating_tb.sv
// Bench: host end and device end joined by the bundle, style 1 then 0.
// Assumes pull-ups on the ack/ready and interrupt wires.
module host_port_irq_gating_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic style = 1'b1;
  logic req = 1'b0;
  logic req_wr = 1'b0;
  logic req_pa = 1'b0;
  logic [4:0] req_addr = 5'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] pa_rdata = 8'h00;
  logic [5:0] evt = 6'h00;
  logic busy, done, pa_cyc, pa_wr, ack_lvl, irq_lvl;
  logic [7:0] rdata, pa_wdata, rd, pa_seen;
  logic [5:0] status;
  int n_errors = 0;
  int samples_checked = 0;
  hpi_bus_if hpi_bus_if_inst ();
  assign ack_lvl = hpi_bus_if_inst.ack_oe ? hpi_bus_if_inst.ack_val : 1'b1;
  assign irq_lvl = hpi_bus_if_inst.irq_oe ? hpi_bus_if_inst.irq_val : 1'b1;
  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (sys_rst_in)
      pa_seen <= 8'h00;
    else if (pa_cyc === 1'b1 && pa_wr === 1'b1)
      pa_seen <= pa_wdata;
  end
  hpi_device hpi_device_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .bus(hpi_bus_if_inst),
    .irq_event_in(evt), .periph_rdata_in(pa_rdata), .periph_cycle_out(pa_cyc), .periph_write_out(pa_wr),
    .periph_wdata_out(pa_wdata), .status_out(status));
  hpi_host hpi_host_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .bus(hpi_bus_if_inst),
    .style_in(style), .req_in(req), .req_write_in(req_wr), .req_periph_in(req_pa), .req_addr_in(req_addr),
    .req_wdata_in(req_wdata), .ack_level_in(ack_lvl), .busy_out(busy), .done_out(done), .rdata_out(rdata));
  hpi_properties hpi_properties_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .bus_style_select(hpi_bus_if_inst.bus_style_select), .reg_select_n(hpi_bus_if_inst.reg_select_n),
    .periph_a_select_n(hpi_bus_if_inst.periph_a_select_n), .data_strobe_n(hpi_bus_if_inst.data_strobe_n),
    .read_write_n(hpi_bus_if_inst.read_write_n), .io_write_strobe_n(hpi_bus_if_inst.io_write_strobe_n),
    .io_read_strobe_n(hpi_bus_if_inst.io_read_strobe_n), .data_host_oe(hpi_bus_if_inst.data_host_oe),
    .data_dev_oe(hpi_bus_if_inst.data_dev_oe), .ack_val(hpi_bus_if_inst.ack_val),
    .ack_oe(hpi_bus_if_inst.ack_oe), .irq_val(hpi_bus_if_inst.irq_val), .irq_oe(hpi_bus_if_inst.irq_oe));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic pa, input logic [4:0] a, input logic [7:0] wd);
    int n;
    @(posedge clock_in);
    #2;
    req = 1'b1;
    req_wr = wr;
    req_pa = pa;
    req_addr = a;
    req_wdata = wd;
    n = 0;
    do begin
      @(posedge clock_in);
      #2;
      req = 1'b0;
      n++;
    end while (done !== 1'b1 && n < 60);
    // A hung handshake closes the run
    if (n >= 60) begin
      n_errors++;
      end_sim();
    end
    rd = rdata;
    check("busy", {7'h00, busy}, 8'h00);
  endtask : xfer
  task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
    xfer(1'b0, 1'b0, a, 8'h00);
    check(what, rd, exp);
  endtask : rd_chk
  task automatic chk_irq(input logic act);
    check("irq pin", {7'h00, irq_lvl}, {7'h00, style ? ~act : act});
  endtask : chk_irq
  task automatic run_test();
    logic [7:0] e;
    rd_chk("mask rst", hpi_pkg::ADDR_IRQ_MASK, {2'h0, hpi_pkg::MASK_RESET});
    rd_chk("ident", hpi_pkg::ADDR_CHIP_ID, hpi_pkg::CHIP_ID_VALUE);
    rd_chk("status rst", hpi_pkg::ADDR_IRQ_CLEAR, 8'h00);
    chk_irq(1'b0);
    evt = 6'h3F;
    @(posedge clock_in);
    #2;
    evt = 6'h00;
    repeat (3) @(posedge clock_in);
    #2;
    check("status set", {2'h0, status}, 8'h3F);
    chk_irq(1'b0);
    rd_chk("status rd", hpi_pkg::ADDR_IRQ_CLEAR, 8'h3F);
    xfer(1'b1, 1'b0, hpi_pkg::ADDR_IRQ_MASK, 8'hFE);
    rd_chk("mask rd", hpi_pkg::ADDR_IRQ_MASK, 8'h3E);
    chk_irq(1'b1);
    e = 8'h3F;
    for (int b = 5; b >= 0; b--) begin
      xfer(1'b1, 1'b0, hpi_pkg::ADDR_IRQ_CLEAR, 8'hC0 | (8'h01 << b));
      e = e & ~(8'h01 << b);
      check("clear bit", {2'h0, status}, e);
      chk_irq(e[0]);
    end
    xfer(1'b1, 1'b0, hpi_pkg::ADDR_CHIP_ID, 8'h00);
    rd_chk("ident ro", hpi_pkg::ADDR_CHIP_ID, hpi_pkg::CHIP_ID_VALUE);
    rd_chk("unmapped", 5'h05, 8'h00);
    pa_rdata = 8'hA5;
    xfer(1'b0, 1'b1, hpi_pkg::ADDR_IRQ_MASK, 8'h00);
    check("pa read", rd, 8'hA5);
    xfer(1'b1, 1'b1, hpi_pkg::ADDR_IRQ_MASK, 8'h5C);
    check("pa write", pa_seen, 8'h5C);
    rd_chk("mask kept", hpi_pkg::ADDR_IRQ_MASK, 8'h3E);
  endtask : run_test
  initial begin
    for (int s = 1; s >= 0; s--) begin
      sys_rst_in = 1'b1;
      style = s[0];
      repeat (6) @(posedge clock_in);
      #2;
      sys_rst_in = 1'b0;
      run_test();
      $display("test style %0d done", s);
    end
    end_sim();
  end
endmodule : host_port_irq_gating_tb
